// *** hw/rtcc_top.sv ***
// BCD time, calendar and time alarm block with a plain register port
//
// Operation
// - Time request halts seconds, minutes, hours
// - Calendar request halts day through century
// - Time event: minute, hour, midnight, noon
// - Calendar event: week, month, year; 11 reserved
// - Hour mode bit: 0 24-hour, 1 12-hour
// - Seconds field BCD 00 to 59
// - Minutes field BCD 00 to 59
// - Hours 01-12 or 00-23 per mode
// - Bit 22 is PM; 24-hour entries must have it zero, stored PM kept on a switch to 24-hour
// - Calendar resets to 0x01819819
// - Century BCD 19 or 20
// - Year BCD 00 to 99
// - Month BCD 01 to 12
// - Weekday cycles 1-7, independent of date
// - Date BCD 01 to 31
// - Bit 7 enables seconds alarm match
// - Bit 15 enables minutes alarm match
// - Bit 23 enables hour and PM match
// - Alarm flag when all enabled fields match
// - Bad entries refused, validity flag set
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

`include "rtcc_regs.svh"

module rtcc_top
    import rtcc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sec_tick_in,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction : bcd_in

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim, input logic [7:0] first);
        if (v == lim) begin
            return first;
        end else if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end else begin
            return {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    // Every year divisible by four is leap, 1900 included, by design
    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == 8'h02) begin
            return leap ? 8'h29 : 8'h28;
        end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
            return 8'h30;
        end else begin
            return 8'h31;
        end
    endfunction : month_len

    // ****************************************
    // Second tick synchroniser
    // ****************************************
    logic tick_s1_q, tick_s2_q, tick_s3_q, tick_lvl_q;
    // Edge taken from the agreed level only, so a one-flop glitch never counts
    wire tick_agree = (tick_s2_q == tick_s3_q);
    wire tick = tick_agree && tick_s3_q && !tick_lvl_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
            tick_lvl_q <= 1'b0;
        end else begin
            tick_s1_q <= sec_tick_in;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
            if (tick_agree) begin
                tick_lvl_q <= tick_s3_q;
            end
        end
    end

    // ****************************************
    // State
    // ****************************************
    logic treq_q, creq_q, hr12_q;
    rtcc_tev_type tev_q;
    rtcc_cev_type cev_q;
    logic [7:0] sec_q, min_q, hour_q;
    logic pm_q;
    logic [7:0] century_field_q, year_q, month_q, day_q, date_q;
    logic [7:0] a_sec_q, a_min_q, a_hour_q;
    logic a_pm_q, a_seconds_match_enable_q, a_minutes_match_enable_q, a_hours_match_enable_q;
    logic [4:0] stat_q;
    logic [2:0] valid_q;
    logic [31:0] reg_rdata_q;

    // ****************************************
    // Write decode and entry checks
    // ****************************************
    wire wr_mode = reg_wr && (reg_addr == `RTCC_OFS_MODE);
    wire wr_hmode = reg_wr && (reg_addr == `RTCC_OFS_HMODE);
    wire wr_time = reg_wr && (reg_addr == `RTCC_OFS_TIME);
    wire wr_cal = reg_wr && (reg_addr == `RTCC_OFS_CAL);
    wire wr_talrm = reg_wr && (reg_addr == `RTCC_OFS_TALRM);
    wire wr_sclr = reg_wr && (reg_addr == `RTCC_OFS_SCLR);

    wire [7:0] w_sec = {1'b0, reg_wdata[6:0]};
    wire [7:0] w_min = {1'b0, reg_wdata[14:8]};
    wire [7:0] w_hour = {2'b00, reg_wdata[21:16]};
    wire w_pm = reg_wdata[`RTCC_TIME_PM];
    wire [7:0] w_century_field = {1'b0, reg_wdata[6:0]};
    wire [7:0] w_year = reg_wdata[15:8];
    wire [7:0] w_month = {3'b000, reg_wdata[20:16]};
    wire [7:0] w_day = {5'b00000, reg_wdata[23:21]};
    wire [7:0] w_date = {2'b00, reg_wdata[29:24]};

    wire w_hour_ok = hr12_q ? bcd_in(w_hour, 8'h01, 8'h12)
                            : (bcd_in(w_hour, 8'h00, 8'h23) && !w_pm);
    wire w_ms_ok = bcd_in(w_sec, 8'h00, 8'h59) && bcd_in(w_min, 8'h00, 8'h59);
    wire w_cal_ok = bcd_in(w_century_field, 8'h19, 8'h20)
                    && bcd_in(w_year, 8'h00, 8'h99)
                    && bcd_in(w_month, 8'h01, 8'h12)
                    && bcd_in(w_day, 8'h01, 8'h07)
                    && bcd_in(w_date, 8'h01, 8'h31)
                    && (w_date <= month_len(w_month, w_year));

    // Counters take software values only while halted
    wire time_wr_go = wr_time && treq_q;
    wire cal_wr_go = wr_cal && creq_q;
    wire time_load = time_wr_go && w_ms_ok && w_hour_ok;
    wire cal_load = cal_wr_go && w_cal_ok;
    // Alarm entry reuses the time checks; hour range follows the current mode
    wire talrm_load = wr_talrm && w_ms_ok && w_hour_ok;

    // ****************************************
    // Counting
    // ****************************************
    wire time_run = tick && !treq_q;
    wire sec_wrap = (sec_q == 8'h59);
    wire min_wrap = sec_wrap && (min_q == 8'h59);
    wire [7:0] sec_c = bcd_inc(sec_q, 8'h59, 8'h00);
    wire [7:0] min_c = sec_wrap ? bcd_inc(min_q, 8'h59, 8'h00) : min_q;

    logic [7:0] hour_c;
    logic pm_c, day_carry, noon_hit;

    // In 12-hour mode PM flips on the 11 to 12 step
    always_comb begin
        hour_c = hour_q;
        pm_c = pm_q;
        day_carry = 1'b0;
        noon_hit = 1'b0;
        if (min_wrap) begin
            if (!hr12_q) begin
                hour_c = bcd_inc(hour_q, 8'h23, 8'h00);
                day_carry = (hour_q == 8'h23);
                noon_hit = (hour_q == 8'h11);
            end else begin
                hour_c = bcd_inc(hour_q, 8'h12, 8'h01);
                if (hour_q == 8'h11) begin
                    pm_c = !pm_q;
                    day_carry = pm_q;
                    noon_hit = !pm_q;
                end
            end
        end
    end

    // Midnight carry into the calendar is lost while the calendar is halted
    wire cal_run = time_run && day_carry && !creq_q;
    wire date_wrap = (date_q == month_len(month_q, year_q));
    wire month_wrap = date_wrap && (month_q == 8'h12);
    wire year_wrap = month_wrap && (year_q == 8'h99);
    wire [7:0] day_c = bcd_inc(day_q, 8'h07, 8'h01);
    wire [7:0] date_c = bcd_inc(date_q, month_len(month_q, year_q), 8'h01);
    wire [7:0] month_c = date_wrap ? bcd_inc(month_q, 8'h12, 8'h01) : month_q;
    wire [7:0] year_c = month_wrap ? bcd_inc(year_q, 8'h99, 8'h00) : year_q;
    wire [7:0] century_field_c = year_wrap ? bcd_inc(century_field_q, 8'h20, 8'h19) : century_field_q;

    // ****************************************
    // Events and alarm
    // ****************************************
    wire tev_hit = (tev_q == RTCC_TEV_MINUTE) ? sec_wrap
                 : (tev_q == RTCC_TEV_HOUR) ? min_wrap
                 : (tev_q == RTCC_TEV_MIDNIGHT) ? day_carry
                 : noon_hit;
    // Weekday 1 is taken as Monday
    wire cev_hit = (cev_q == RTCC_CEV_WEEK) ? (day_c == 8'h01)
                 : (cev_q == RTCC_CEV_MONTH) ? date_wrap
                 : (cev_q == RTCC_CEV_YEAR) ? month_wrap
                 : 1'b0;

    // Compared with next-second values, so the flag lands on the matching tick
    wire alarm_any = a_seconds_match_enable_q || a_minutes_match_enable_q || a_hours_match_enable_q;
    wire alarm_match = alarm_any
                       && (!a_seconds_match_enable_q || (a_sec_q == sec_c))
                       && (!a_minutes_match_enable_q || (a_min_q == min_c))
                       && (!a_hours_match_enable_q || (a_hour_q == hour_c && a_pm_q == pm_c));

    // Acknowledge only when a request bit actually rises
    wire ack_set = wr_mode && ((reg_wdata[`RTCC_MODE_TREQ] && !treq_q) || (reg_wdata[`RTCC_MODE_CREQ] && !creq_q));
    wire [4:0] stat_set;
    assign stat_set[`RTCC_ST_ACK] = ack_set;
    assign stat_set[`RTCC_ST_ALARM] = time_run && alarm_match;
    assign stat_set[`RTCC_ST_SEC] = time_run;
    assign stat_set[`RTCC_ST_TIME_EVENT_FLAG] = time_run && tev_hit;
    assign stat_set[`RTCC_ST_CALENDAR_EVENT_FLAG] = cal_run && cev_hit;
    wire [4:0] stat_clr = wr_sclr ? reg_wdata[4:0] : 5'h00;

    // ****************************************
    // Control and alarm registers
    // ****************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            treq_q <= 1'b0;
            creq_q <= 1'b0;
            tev_q <= RTCC_TEV_MINUTE;
            cev_q <= RTCC_CEV_WEEK;
            hr12_q <= 1'b0;
            stat_q <= 5'h00;
            valid_q <= 3'h0;
        end else begin
            if (wr_mode) begin
                treq_q <= reg_wdata[`RTCC_MODE_TREQ];
                creq_q <= reg_wdata[`RTCC_MODE_CREQ];
                tev_q <= rtcc_tev_type'(reg_wdata[`RTCC_MODE_TEV_LSB +: 2]);
                cev_q <= rtcc_cev_type'(reg_wdata[`RTCC_MODE_CEV_LSB +: 2]);
            end
            if (wr_hmode) begin
                hr12_q <= reg_wdata[0];
            end
            // Set wins over a clear landing in the same cycle
            stat_q <= (stat_q & ~stat_clr) | stat_set;
            if (time_wr_go) begin
                valid_q[`RTCC_VE_TIME] <= !time_load;
            end
            if (cal_wr_go) begin
                valid_q[`RTCC_VE_CAL] <= !cal_load;
            end
            if (wr_talrm) begin
                valid_q[`RTCC_VE_TALRM] <= !talrm_load;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_sec_q <= 8'h00;
            a_min_q <= 8'h00;
            a_hour_q <= 8'h00;
            a_pm_q <= 1'b0;
            a_seconds_match_enable_q <= 1'b0;
            a_minutes_match_enable_q <= 1'b0;
            a_hours_match_enable_q <= 1'b0;
        end else if (talrm_load) begin
            a_sec_q <= w_sec;
            a_min_q <= w_min;
            a_hour_q <= w_hour;
            a_pm_q <= w_pm;
            a_seconds_match_enable_q <= reg_wdata[`RTCC_TALRM_SECONDS_MATCH_ENABLE];
            a_minutes_match_enable_q <= reg_wdata[`RTCC_TALRM_MINUTES_MATCH_ENABLE];
            a_hours_match_enable_q <= reg_wdata[`RTCC_TALRM_HOURS_MATCH_ENABLE];
        end
    end

    // ****************************************
    // Time and calendar counters
    // ****************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sec_q <= 8'h00;
            min_q <= 8'h00;
            hour_q <= 8'h00;
            pm_q <= 1'b0;
        end else if (time_load) begin
            sec_q <= w_sec;
            min_q <= w_min;
            hour_q <= w_hour;
            pm_q <= w_pm;
        end else if (time_run) begin
            sec_q <= sec_c;
            min_q <= min_c;
            hour_q <= hour_c;
            pm_q <= pm_c;
        end
    end

    // Calendar reset value unpacked field by field
    localparam logic [31:0] CAL_RST = `RTCC_RST_CAL;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            century_field_q <= {1'b0, CAL_RST[6:0]};
            year_q <= CAL_RST[15:8];
            month_q <= {3'b000, CAL_RST[20:16]};
            day_q <= {5'b00000, CAL_RST[23:21]};
            date_q <= {2'b00, CAL_RST[29:24]};
        end else if (cal_load) begin
            century_field_q <= w_century_field;
            year_q <= w_year;
            month_q <= w_month;
            day_q <= w_day;
            date_q <= w_date;
        end else if (cal_run) begin
            century_field_q <= century_field_c;
            year_q <= year_c;
            month_q <= month_c;
            day_q <= day_c;
            date_q <= date_c;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire [31:0] rd_mode = {14'h0, cev_q, 6'h0, tev_q, 6'h0, creq_q, treq_q};
    // Hours read back as stored; no 12/24 conversion
    wire [31:0] rd_time = {9'h0, pm_q, hour_q[5:0], 1'b0, min_q[6:0], 1'b0, sec_q[6:0]};
    wire [31:0] rd_cal = {2'b00, date_q[5:0], day_q[2:0], month_q[4:0], year_q, 1'b0, century_field_q[6:0]};
    wire [31:0] rd_talrm = {8'h0, a_hours_match_enable_q, a_pm_q, a_hour_q[5:0], a_minutes_match_enable_q, a_min_q[6:0],
                            a_seconds_match_enable_q, a_sec_q[6:0]};
    // Unmapped and write-only offsets read as zero
    logic [31:0] rd_mux;

    always_comb begin
        if (reg_addr == `RTCC_OFS_MODE) begin
            rd_mux = rd_mode;
        end else if (reg_addr == `RTCC_OFS_HMODE) begin
            rd_mux = {31'h0, hr12_q};
        end else if (reg_addr == `RTCC_OFS_TIME) begin
            rd_mux = rd_time;
        end else if (reg_addr == `RTCC_OFS_CAL) begin
            rd_mux = rd_cal;
        end else if (reg_addr == `RTCC_OFS_TALRM) begin
            rd_mux = rd_talrm;
        end else if (reg_addr == `RTCC_OFS_STAT) begin
            rd_mux = {27'h0, stat_q};
        end else if (reg_addr == `RTCC_OFS_VALID) begin
            rd_mux = {29'h0, valid_q};
        end else begin
            rd_mux = `RTCC_RST_ZERO;
        end
    end

    // Zero between reads keeps stale data off the port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= `RTCC_RST_ZERO;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : `RTCC_RST_ZERO;
        end
    end

    assign reg_rdata = reg_rdata_q;

endmodule : rtcc_top

// *** inc/rtcc_regs.svh ***
// Register offsets, field positions and reset values of the calendar clock
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RTCC_OFS_MODE 8'h00
`define RTCC_OFS_HMODE 8'h04
`define RTCC_OFS_TIME 8'h08
`define RTCC_OFS_CAL 8'h0C
`define RTCC_OFS_TALRM 8'h10
`define RTCC_OFS_STAT 8'h18
`define RTCC_OFS_SCLR 8'h1C
`define RTCC_OFS_VALID 8'h2C

// ****************************************
// Field positions
// ****************************************
`define RTCC_MODE_TREQ 0
`define RTCC_MODE_CREQ 1
`define RTCC_MODE_TEV_LSB 8
`define RTCC_MODE_CEV_LSB 16
`define RTCC_TIME_PM 22
`define RTCC_TALRM_SECONDS_MATCH_ENABLE 7
`define RTCC_TALRM_MINUTES_MATCH_ENABLE 15
`define RTCC_TALRM_HOURS_MATCH_ENABLE 23
`define RTCC_ST_ACK 0
`define RTCC_ST_ALARM 1
`define RTCC_ST_SEC 2
`define RTCC_ST_TIME_EVENT_FLAG 3
`define RTCC_ST_CALENDAR_EVENT_FLAG 4
`define RTCC_VE_TIME 0
`define RTCC_VE_CAL 1
`define RTCC_VE_TALRM 2

// ****************************************
// Reset values
// ****************************************
`define RTCC_RST_CAL 32'h01819819
`define RTCC_RST_ZERO 32'h00000000

`endif

// *** inc/rtcc_pkg.sv ***
// Types shared by the calendar clock
package rtcc_pkg;

    typedef enum logic [1:0] {
        RTCC_TEV_MINUTE = 2'h0,
        RTCC_TEV_HOUR = 2'h1,
        RTCC_TEV_MIDNIGHT = 2'h2,
        RTCC_TEV_NOON = 2'h3
    } rtcc_tev_type;

    typedef enum logic [1:0] {
        RTCC_CEV_WEEK = 2'h0,
        RTCC_CEV_MONTH = 2'h1,
        RTCC_CEV_YEAR = 2'h2,
        RTCC_CEV_RSVD = 2'h3
    } rtcc_cev_type;

endpackage : rtcc_pkg

// *** verif/rtcc_top_assertions.sv ***
// Port-level assertions for the calendar clock
`timescale 1ns/1ps
module rtcc_top_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sec_tick_in,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // ****************
    // Helper state
    // ****************
    // Writes or counting may move the calendar off its reset value
    logic touched_q, treq_q, bad_sec_q;
    wire logic rd_cal = reg_rd && reg_addr == 8'h0C;
    wire logic rd_time = reg_rd && reg_addr == 8'h08;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            touched_q <= 1'b0;
        end else if (sec_tick_in || (reg_wr && (reg_addr == 8'h08 || reg_addr == 8'h0C))) begin
            touched_q <= 1'b1;
        end
    end
    // A time write is only checked while the time request stands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            treq_q <= 1'b0;
            bad_sec_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 8'h00) begin
                treq_q <= reg_wdata[0];
            end
            if (reg_wr && reg_addr == 8'h08 && treq_q) begin
                bad_sec_q <= (reg_wdata[3:0] > 4'h9);
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ****************
    // Properties
    // ****************
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_cal_reset_val: assert property (rd_cal && !touched_q |=> reg_rdata == 32'h01819819)
        else $error("calendar reset value wrong");
    a_hmode_pad: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:1] == 31'h0)
        else $error("hour mode upper bits not zero");
    a_sec_bcd: assert property (rd_time |=> reg_rdata[3:0] <= 4'h9 && reg_rdata[6:4] <= 3'h5)
        else $error("seconds not BCD 00 to 59");
    a_min_bcd: assert property (rd_time |=> reg_rdata[11:8] <= 4'h9 && reg_rdata[14:12] <= 3'h5)
        else $error("minutes not BCD 00 to 59");
    a_hour_range: assert property (rd_time |=>
        reg_rdata[21:16] inside {[6'h00:6'h09], [6'h10:6'h19], [6'h20:6'h23]})
        else $error("hours out of range");
    a_century_field_range: assert property (rd_cal |=> reg_rdata[6:0] inside {7'h19, 7'h20})
        else $error("century not 19 or 20");
    a_year_bcd: assert property (rd_cal |=> reg_rdata[11:8] <= 4'h9 && reg_rdata[15:12] <= 4'h9)
        else $error("year not BCD");
    a_month_range: assert property (rd_cal |=> reg_rdata[20:16] inside {[5'h01:5'h09], [5'h10:5'h12]})
        else $error("month out of range");
    a_weekday_range: assert property (rd_cal |=> reg_rdata[23:21] != 3'h0)
        else $error("weekday zero");
    a_date_range: assert property (rd_cal |=>
        reg_rdata[29:24] inside {[6'h01:6'h09], [6'h10:6'h19], [6'h20:6'h29], [6'h30:6'h31]})
        else $error("date out of range");
    a_bad_sec_flag: assert property (reg_rd && reg_addr == 8'h2C && bad_sec_q |=> reg_rdata[0])
        else $error("bad seconds entry not flagged");
    c_cal_read: cover property (rd_cal);
    c_bad_sec: cover property (reg_wr && reg_addr == 8'h08 && reg_wdata[3:0] > 4'h9);
    c_twelve_hour: cover property (reg_wr && reg_addr == 8'h04 && reg_wdata[0]);
endmodule : rtcc_top_assertions

// *** verif/rtcc_top_bench.sv ***
// Self-checking bench for the calendar clock
`timescale 1ns/1ps
module rtcc_top_bench;
    logic clk, arst_n, sec_tick_in, reg_wr, reg_rd, rd_pend;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int n_fail, n_tests, s;
    logic [31:0] exp_q[$], msk_q[$];
    string nm_q[$];
    logic [31:0] tpre[3] = '{32'h00005959, 32'h00235959, 32'h00115959};
    logic [2:0] tev_exp[4] = '{3'b111, 3'b111, 3'b010, 3'b100};
    logic [31:0] cpre[2] = '{32'h31F29919, 32'h29420020};
    logic [31:0] cnext[2] = '{32'h01210020, 32'h01630020};
    logic [1:0] cev_exp[4] = '{2'b01, 2'b11, 2'b01, 2'b00};
    logic [31:0] alm[5] = '{32'h80, 32'h8180, 32'h00800080, 32'h00810080, 32'h0};
    logic [4:0] alm_exp = 5'b00101;
    logic [7:0] zofs[7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h2C, 8'h14};
    rtcc_top i_rtcc_top (.clk(clk), .arst_n(arst_n), .sec_tick_in(sec_tick_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****************
    // Bus tasks and scoreboard
    // ****************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        nm_q.push_back($sformatf("reg_%h", a));
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    // Tick held high and low well beyond the three-flop synchroniser
    task automatic tick;
        @(posedge clk);
        sec_tick_in <= 1'b1;
        repeat (4) @(posedge clk);
        sec_tick_in <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : tick
    task automatic load(input logic [31:0] mode, input logic [31:0] t, input logic [31:0] c);
        wr(8'h00, mode | 32'h3);
        rd(8'h18, 32'h1, 32'h1);
        wr(8'h1C, 32'h1);
        wr(8'h08, t);
        wr(8'h0C, c);
        wr(8'h00, mode);
        wr(8'h1C, 32'h1F);
    endtask : load
    function automatic logic [31:0] bcd(input int v);
        return 32'((v / 10) * 16 + v % 10);
    endfunction : bcd
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        rd_pend <= reg_rd;
        if (rd_pend) begin
            if (exp_q.size() == 0) chk("unexpected_read", 32'h1, 32'h0);
            else chk(nm_q.pop_front(), reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        chk("run_length", 32'h1, 32'h0);
        give_verdict;
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        {arst_n, sec_tick_in, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        n_fail = 0;
        n_tests = 0;
        s = $urandom(32'hF481575E);
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h0C, 32'h01819819);
        foreach (zofs[i]) rd(zofs[i], 32'h0);
        wr(8'h08, 32'h00123456);
        wr(8'h0C, 32'h02A19819);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h01819819);
        $display("test reset done");
        wr(8'h00, 32'h1);
        rd(8'h18, 32'h1, 32'h1);
        wr(8'h1C, 32'h1F);
        wr(8'h08, 32'h00235958);
        tick;
        rd(8'h08, 32'h00235958);
        wr(8'h00, 32'h0);
        tick;
        tick;
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h02A19819);
        rd(8'h18, 32'h0C, 32'h1C);
        $display("test halt done");
        for (int p = 0; p < 3; p++) for (int c = 0; c < 4; c++) begin
            load(32'(c) << 8, tpre[p], 32'h31F29919);
            tick;
            rd(8'h18, 32'({tev_exp[c][p], 3'h0}), 32'h8);
        end
        $display("test time events done");
        load(32'h0, 32'h00235959, 32'h31F29919);
        wr(8'h00, 32'h2);
        tick;
        rd(8'h0C, 32'h31F29919);
        rd(8'h08, 32'h0);
        for (int p = 0; p < 2; p++) for (int c = 0; c < 4; c++) begin
            load(32'(c) << 16, 32'h00235959, cpre[p]);
            tick;
            rd(8'h18, 32'({cev_exp[c][p], 4'h0}), 32'h10);
            rd(8'h0C, cnext[p]);
        end
        $display("test calendar done");
        wr(8'h04, 32'h1);
        rd(8'h04, 32'h1);
        load(32'h0, 32'h00115959, 32'h31F29919);
        tick;
        rd(8'h08, 32'h00520000);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h00130000);
        rd(8'h2C, 32'h1, 32'h1);
        rd(8'h08, 32'h00520000);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h00410000);
        rd(8'h2C, 32'h1, 32'h1);
        wr(8'h08, 32'h0000005A);
        rd(8'h2C, 32'h1, 32'h1);
        wr(8'h08, 32'h00000000);
        rd(8'h2C, 32'h0, 32'h1);
        $display("test hour mode done");
        foreach (alm[i]) begin
            s = $urandom_range(58, 0);
            load(32'h0, bcd(s), 32'h31F29919);
            wr(8'h10, alm[i] | bcd(s + 1));
            tick;
            rd(8'h18, 32'({alm_exp[i], 1'b0}), 32'h2);
        end
        wr(8'h10, 32'h5A);
        rd(8'h2C, 32'h4, 32'h4);
        $display("test alarm done");
        repeat (4) @(posedge clk);
        chk("pending_reads", 32'(exp_q.size()), 32'h0);
        give_verdict;
    end
endmodule : rtcc_top_bench
bind rtcc_top rtcc_top_assertions i_rtcc_top_assertions (.clk(clk), .arst_n(arst_n), .sec_tick_in(sec_tick_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
